/* File: logic/rsc_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the reset source control block.
// Assumes: A 20 MHz bus clock.
// Notes: Definitions only.
`ifndef RSC_REGS_SVH
`define RSC_REGS_SVH
`define RSC_CTRL_OFFSET 12'h000
`define RSC_STATUS_OFFSET 12'h004
`define RSC_CTRL_SWRST_BIT 0
`define RSC_CTRL_BOEN_BIT 1
`define RSC_CTRL_WDSEL_BIT 2
`define RSC_CTRL_PMLO_BIT 4
`define RSC_CTRL_PMHI_BIT 5
`define RSC_CTRL_RESET 8'h00
`define RSC_CLK_KHZ 20000
`define RSC_BO_RESTART_DELAY_US 1000
`define RSC_BO_RESTART_CYCLES ((`RSC_BO_RESTART_DELAY_US * `RSC_CLK_KHZ) / 1000)
`define RSC_SOFT_HOLD_CYCLES 20
`define RSC_RESP_OKAY 2'h0
`define RSC_RESP_SLVERR 2'h2
`endif

/* File: logic/rsc_pkg.sv */
// Purpose: Types shared by the reset source control block.
// Assumes: Nothing beyond the header.
// Notes: States and reset causes.
package rsc_pkg;
  typedef enum logic [1:0] {RSC_RUN, RSC_HOLD, RSC_BO_WAIT, RSC_SOFT_HOLD} rsc_state_t;
  typedef enum logic [1:0] {RSC_CAUSE_PIN, RSC_CAUSE_BROWNOUT, RSC_CAUSE_SOFT, RSC_CAUSE_WDOG} rsc_cause_t;
endpackage

/* File: logic/rsc_top.sv */
// Purpose: Combines the reset pin, brown-out, software and watchdog resets into one sequenced reset.
// Assumes: All pin and monitor inputs are synchronous to aclk; registers sit on an AXI4-Lite slave.
// Notes: Outputs are registered, so every reaction shows one cycle after its cause.
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_top #(
  parameter int BO_RESTART_CYCLES = `RSC_BO_RESTART_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reset_pin_n,
  input wire logic supply_at_or_below_trip,
  input wire logic supply_at_or_above_release,
  input wire logic stop_mode,
  input wire logic watchdog_underflow,
  input wire logic ram_write_busy,
  input wire logic boot_mode_strap,
  input wire logic bus_width_8,
  input wire logic hold_request,
  output logic cpu_reset_n,
  output logic osc_reset,
  output logic sfr_full_reset,
  output logic sfr_partial_reset,
  output logic fetch_reset_vector,
  output logic pins_in_reset,
  output logic port0_oe,
  output logic port1_oe,
  output logic addr_oe,
  output logic write_strobe_n_out,
  output logic write_strobe_n_oe,
  output logic read_strobe_n_out,
  output logic read_strobe_n_oe,
  output logic upper_lane_enable_n_oe,
  output logic bus_clock_oe,
  output logic hold_acknowledge,
  output logic hold_acknowledge_oe,
  output logic aux_high_out,
  output logic aux_high_oe
);

  logic awready_reg, awready_next, wready_reg, wready_next;
  logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
  logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
  logic [31:0] rdata_reg, rdata_next;
  logic wr_fire, rd_fire, sw_req_pulse;
  logic boen_reg, boen_next, wdsel_reg, wdsel_next;
  logic [1:0] pmode_reg, pmode_next;
  logic ram_suspect_reg, ram_suspect_next;
  rsc_pkg::rsc_state_t state_reg, state_next;
  rsc_pkg::rsc_cause_t cause_reg, cause_next;
  logic [19:0] cnt_reg, cnt_next;
  logic brownout_trip, wdog_trip;
  logic cpu_rst_n_next, osc_rst_next, full_next, part_next, fetch_next, in_rst_next;
  logic [12:0] pin_next, pin_reg;

  assign wr_fire = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign sw_req_pulse = wr_fire && (s_axi_awaddr == `RSC_CTRL_OFFSET) && s_axi_wstrb[0]
    && s_axi_wdata[`RSC_CTRL_SWRST_BIT];
  // Brown-out is masked in stop mode, so it can neither reset nor wake the part there.
  assign brownout_trip = boen_reg && !stop_mode && supply_at_or_below_trip;
  assign wdog_trip = wdsel_reg && watchdog_underflow;

  // Address and data are taken together, so the order in which they arrive does not matter.
  always_comb
  begin
    awready_next = s_axi_awvalid && s_axi_wvalid && !awready_reg && !bvalid_reg;
    wready_next = awready_next;
    bvalid_next = bvalid_reg;
    bresp_next = bresp_reg;
    if (bvalid_reg && s_axi_bready)
      bvalid_next = 1'b0;
    if (wr_fire)
    begin
      bvalid_next = 1'b1;
      bresp_next = (s_axi_awaddr == `RSC_CTRL_OFFSET) ? `RSC_RESP_OKAY : `RSC_RESP_SLVERR;
    end
    arready_next = s_axi_arvalid && !arready_reg && !rvalid_reg;
    rvalid_next = rvalid_reg;
    rresp_next = rresp_reg;
    rdata_next = rdata_reg;
    if (rvalid_reg && s_axi_rready)
      rvalid_next = 1'b0;
    if (rd_fire)
    begin
      rvalid_next = 1'b1;
      rresp_next = `RSC_RESP_OKAY;
      rdata_next = 32'h0000_0000;
      if (s_axi_araddr == `RSC_CTRL_OFFSET)
      begin
        rdata_next[`RSC_CTRL_BOEN_BIT] = boen_reg;
        rdata_next[`RSC_CTRL_WDSEL_BIT] = wdsel_reg;
        rdata_next[`RSC_CTRL_PMHI_BIT:`RSC_CTRL_PMLO_BIT] = pmode_reg;
      end
      else if (s_axi_araddr == `RSC_STATUS_OFFSET)
        rdata_next[5:0] = {ram_suspect_reg, cause_reg, state_reg, cpu_reset_n};
      else
        rresp_next = `RSC_RESP_SLVERR;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b0;
      wready_reg <= 1'b0;
      bvalid_reg <= 1'b0;
      bresp_reg <= `RSC_RESP_OKAY;
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b0;
      rresp_reg <= `RSC_RESP_OKAY;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      awready_reg <= awready_next;
      wready_reg <= wready_next;
      bvalid_reg <= bvalid_next;
      bresp_reg <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg <= rvalid_next;
      rresp_reg <= rresp_next;
      rdata_reg <= rdata_next;
    end
  end

  // Control bits and the RAM flag. A software write in the same cycle as a reset entry wins.
  always_comb
  begin
    boen_next = boen_reg;
    wdsel_next = wdsel_reg;
    pmode_next = pmode_reg;
    ram_suspect_next = ram_suspect_reg;
    if (state_reg == rsc_pkg::RSC_RUN && !reset_pin_n && ram_write_busy)
      ram_suspect_next = 1'b1;
    if (!reset_pin_n)
    begin
      // The pin clears all three; the end of a soft hold clears only the watchdog select; a brown-out leaves the enable untouched.
      boen_next = 1'b0;
      wdsel_next = 1'b0;
      pmode_next = 2'h0;
    end
    else if (state_reg == rsc_pkg::RSC_SOFT_HOLD && cnt_reg == 20'h00000)
      wdsel_next = 1'b0;
    if (wr_fire && s_axi_awaddr == `RSC_CTRL_OFFSET && s_axi_wstrb[0])
    begin
      boen_next = s_axi_wdata[`RSC_CTRL_BOEN_BIT];
      wdsel_next = s_axi_wdata[`RSC_CTRL_WDSEL_BIT];
      pmode_next = s_axi_wdata[`RSC_CTRL_PMHI_BIT:`RSC_CTRL_PMLO_BIT];
    end
    if (rd_fire && s_axi_araddr == `RSC_STATUS_OFFSET && !(!reset_pin_n && ram_write_busy))
      ram_suspect_next = 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      boen_reg <= 1'b0;
      wdsel_reg <= 1'b0;
      pmode_reg <= 2'h0;
      ram_suspect_reg <= 1'b0;
    end
    else
    begin
      boen_reg <= boen_next;
      wdsel_reg <= wdsel_next;
      pmode_reg <= pmode_next;
      ram_suspect_reg <= ram_suspect_next;
    end
  end

  // Sequencer. The pin outranks every other source because it also restarts the oscillator.
  always_comb
  begin
    state_next = state_reg;
    cause_next = cause_reg;
    cnt_next = cnt_reg;
    fetch_next = 1'b0;
    if (!reset_pin_n)
    begin
      state_next = rsc_pkg::RSC_HOLD;
      cause_next = rsc_pkg::RSC_CAUSE_PIN;
    end
    else if (brownout_trip)
    begin
      state_next = rsc_pkg::RSC_BO_WAIT;
      cause_next = rsc_pkg::RSC_CAUSE_BROWNOUT;
      cnt_next = 20'(BO_RESTART_CYCLES);
    end
    else
    begin
      unique case (state_reg)
        rsc_pkg::RSC_RUN:
          if (sw_req_pulse || wdog_trip)
          begin
            state_next = rsc_pkg::RSC_SOFT_HOLD;
            cause_next = sw_req_pulse ? rsc_pkg::RSC_CAUSE_SOFT : rsc_pkg::RSC_CAUSE_WDOG;
            cnt_next = 20'(`RSC_SOFT_HOLD_CYCLES);
          end
        rsc_pkg::RSC_HOLD:
        begin
          // The host keeps the pin low long enough for the oscillator to start.
          state_next = rsc_pkg::RSC_RUN;
          fetch_next = 1'b1;
        end
        rsc_pkg::RSC_BO_WAIT:
          if (supply_at_or_above_release)
          begin
            if (cnt_reg == 20'h00000)
            begin
              state_next = rsc_pkg::RSC_RUN;
              fetch_next = 1'b1;
            end
            else
              cnt_next = cnt_reg - 20'h00001;
          end
          else
            cnt_next = 20'(BO_RESTART_CYCLES);
        rsc_pkg::RSC_SOFT_HOLD:
          if (cnt_reg == 20'h00000)
          begin
            state_next = rsc_pkg::RSC_RUN;
            fetch_next = 1'b1;
          end
          else
            cnt_next = cnt_reg - 20'h00001;
      endcase
    end
    in_rst_next = state_next != rsc_pkg::RSC_RUN;
    cpu_rst_n_next = !in_rst_next;
    osc_rst_next = !reset_pin_n;
    // Pin and brown-out flag a full register reset, though of these two only the pin clears this block's control bits; the other two spare the mode bits.
    full_next = in_rst_next && (cause_next == rsc_pkg::RSC_CAUSE_PIN
      || cause_next == rsc_pkg::RSC_CAUSE_BROWNOUT);
    part_next = in_rst_next && !full_next;
    // Order: port0, port1, addr, wr out/oe, rd out/oe, upper lane oe, clock oe, hold ack/oe, aux out/oe.
    pin_next = 13'h0000;
    if (in_rst_next && boot_mode_strap)
    begin
      // Port 1 is an input either way: data lane on a wide bus, plain port on a narrow one.
      pin_next[12:11] = 2'b00;
      pin_next[10] = 1'b1;
      pin_next[9:6] = 4'b1111;
      pin_next[5] = 1'b1;
      pin_next[4] = 1'b1;
      pin_next[3] = hold_request;
      pin_next[2] = 1'b1;
      pin_next[1:0] = 2'b11;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state_reg <= rsc_pkg::RSC_HOLD;
      cause_reg <= rsc_pkg::RSC_CAUSE_PIN;
      cnt_reg <= 20'h00000;
      cpu_reset_n <= 1'b0;
      osc_reset <= 1'b1;
      sfr_full_reset <= 1'b1;
      sfr_partial_reset <= 1'b0;
      fetch_reset_vector <= 1'b0;
      pins_in_reset <= 1'b1;
      pin_reg <= 13'h0000;
    end
    else
    begin
      state_reg <= state_next;
      cause_reg <= cause_next;
      cnt_reg <= cnt_next;
      cpu_reset_n <= cpu_rst_n_next;
      osc_reset <= osc_rst_next;
      sfr_full_reset <= full_next;
      sfr_partial_reset <= part_next;
      fetch_reset_vector <= fetch_next;
      pins_in_reset <= in_rst_next;
      pin_reg <= pin_next;
    end
  end

  assign {port0_oe, port1_oe, addr_oe, write_strobe_n_out, write_strobe_n_oe, read_strobe_n_out,
    read_strobe_n_oe, upper_lane_enable_n_oe, bus_clock_oe, hold_acknowledge, hold_acknowledge_oe,
    aux_high_out, aux_high_oe} = pin_reg;
  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;

endmodule

/* File: tb/rsc_top_chk.sv */
// Purpose: Port-level checks of rsc_top.
// Assumes: Pin and monitor inputs are synchronous to aclk.
// Notes: Held pin states are judged after three reset cycles, so entry latency is left open.
`timescale 1ns/1ns
module rsc_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic reset_pin_n,
  input wire logic boot_mode_strap,
  input wire logic hold_request,
  input wire logic cpu_reset_n,
  input wire logic osc_reset,
  input wire logic sfr_full_reset,
  input wire logic sfr_partial_reset,
  input wire logic fetch_reset_vector,
  input wire logic port0_oe,
  input wire logic port1_oe,
  input wire logic addr_oe,
  input wire logic write_strobe_n_out,
  input wire logic write_strobe_n_oe,
  input wire logic read_strobe_n_out,
  input wire logic read_strobe_n_oe,
  input wire logic upper_lane_enable_n_oe,
  input wire logic bus_clock_oe,
  input wire logic hold_acknowledge,
  input wire logic hold_acknowledge_oe,
  input wire logic aux_high_out,
  input wire logic aux_high_oe
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  sequence s_bus;
    (boot_mode_strap && !cpu_reset_n) [*3];
  endsequence
  property p_pin_hold;
    !reset_pin_n |=> !cpu_reset_n && osc_reset && sfr_full_reset;
  endproperty
  property p_release;
    $rose(reset_pin_n) |-> ##[1:3] fetch_reset_vector;
  endproperty
  property p_fetch;
    fetch_reset_vector |-> cpu_reset_n && !$past(cpu_reset_n) ##1 !fetch_reset_vector;
  endproperty
  property p_single;
    !boot_mode_strap |=> !(port0_oe || port1_oe || addr_oe || write_strobe_n_oe || read_strobe_n_oe
      || upper_lane_enable_n_oe || bus_clock_oe || hold_acknowledge_oe || aux_high_oe);
  endproperty
  property p_bus_data;
    s_bus |-> !port0_oe && !port1_oe && addr_oe;
  endproperty
  property p_bus_ctl;
    s_bus |-> write_strobe_n_out && write_strobe_n_oe && read_strobe_n_out && read_strobe_n_oe
      && upper_lane_enable_n_oe && bus_clock_oe && aux_high_out && aux_high_oe;
  endproperty
  property p_hold;
    s_bus |-> hold_acknowledge_oe && (hold_acknowledge == $past(hold_request));
  endproperty
  property p_soft;
    $rose(sfr_partial_reset) |-> (!cpu_reset_n) [*7] ##1 (!cpu_reset_n) [*7] ##1 (!cpu_reset_n) [*7] ##1 cpu_reset_n;
  endproperty
  property p_kind;
    sfr_partial_reset |-> !cpu_reset_n && !sfr_full_reset;
  endproperty
  a_pin_hold: assert property (p_pin_hold) else $error("pin reset not held");
  a_release: assert property (p_release) else $error("no restart after pin release");
  a_fetch: assert property (p_fetch) else $error("bad vector fetch pulse");
  a_single: assert property (p_single) else $error("pin driven in single-chip mode");
  a_bus_data: assert property (p_bus_data) else $error("bus port states wrong");
  a_bus_ctl: assert property (p_bus_ctl) else $error("bus control states wrong");
  a_hold: assert property (p_hold) else $error("hold acknowledge wrong");
  a_soft: assert property (p_soft) else $error("partial reset length wrong");
  a_kind: assert property (p_kind) else $error("partial reset mixed with full");
  c_fetch: cover property (fetch_reset_vector);
  c_part: cover property ($rose(sfr_partial_reset));
  c_bus: cover property (s_bus);
endmodule
bind rsc_top rsc_chk u_rsc_chk (.*);

/* File: tb/rsc_partner.sv */
// Purpose: External reset circuit and supply monitor facing rsc_top.
// Assumes: aclk stands in for the main oscillator input.
// Notes: The pin is released only once the low hold has been served.
`timescale 1ns/1ns
module rsc_partner #(
  parameter int LOW_CYCLES = 20
) (
  input wire logic aclk,
  input wire logic pin_req,
  input wire logic bo_req,
  output logic reset_pin_n,
  output logic supply_at_or_below_trip,
  output logic supply_at_or_above_release
);
  int low_cnt = 0;
  initial
  begin
    reset_pin_n = 1'b0;
    supply_at_or_below_trip = 1'b0;
    supply_at_or_above_release = 1'b1;
  end
  always @(posedge aclk)
  begin
    supply_at_or_below_trip <= bo_req;
    supply_at_or_above_release <= !bo_req;
    if (pin_req)
    begin
      reset_pin_n <= 1'b0;
      low_cnt <= 0;
    end
    else if (low_cnt < LOW_CYCLES)
      low_cnt <= low_cnt + 1;
    else
      reset_pin_n <= 1'b1;
  end
endmodule

/* File: tb/rsc_top_bench.sv */
// Purpose: Self-checking bench of rsc_top.
// Assumes: aclk stands in for the main oscillator input.
// Notes: The restart delay is shortened so brown-out runs stay short.
`timescale 1ns/1ns
`include "rsc_regs.svh"
module rsc_top_bench;
  localparam int BO = 10;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic stop_mode = 1'b0, watchdog_underflow = 1'b0, ram_write_busy = 1'b0, pin_req = 1'b1, bo_req = 1'b0;
  logic boot_mode_strap = 1'b0, bus_width_8 = 1'b0, hold_request = 1'b0;
  logic reset_pin_n, supply_at_or_below_trip, supply_at_or_above_release;
  logic cpu_reset_n, osc_reset, sfr_full_reset, sfr_partial_reset, fetch_reset_vector, pins_in_reset;
  logic port0_oe, port1_oe, addr_oe, write_strobe_n_out, write_strobe_n_oe, read_strobe_n_out, read_strobe_n_oe;
  logic upper_lane_enable_n_oe, bus_clock_oe, hold_acknowledge, hold_acknowledge_oe, aux_high_out, aux_high_oe;
  logic [17:0] rows [5] = '{18'h20000, 18'h307f7, 18'h3c7ff, 18'h12000, 18'h02000};
  int failures = 0, tests_run = 0, n;
  rsc_top #(.BO_RESTART_CYCLES(BO)) u_rsc_top (.*);
  rsc_partner u_rsc_partner (.*);
  always #25 aclk = ~aclk;
  task chk(input logic [33:0] s, input logic [33:0] e);
    tests_run++;
    if (s !== e)
    begin
      failures++;
      $display("[ERR] %0t saw %h expected %h", $time, s, e);
    end
  endtask
  task summarize;
    if (failures == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wt(ref logic s);
    do
    begin
      @(posedge aclk);
      n++;
    end
    while (s !== 1'b1 && n < 200);
    if (n >= 200)
    begin
      failures++;
      $display("[ERR] %0t wait ran out", $time);
      summarize();
    end
  endtask
  // Address and data are dropped one by one, each on its own ready, though the slave raises both readies together.
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic [1:0] p;
    p = 2'h3;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (p != 2'h0 && n < 200)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready === 1'b1) p[0] = 1'b0;
      if (s_axi_wready === 1'b1) p[1] = 1'b0;
      s_axi_awvalid <= p[0];
      s_axi_wvalid <= p[1];
    end
    wt(s_axi_bvalid);
    // Ready stays high between transfers, so a following call never drives it twice in one step.
    rsp = s_axi_bresp;
  endtask
  task automatic rq(input logic [11:0] a, input logic [33:0] e);
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    wt(s_axi_arready);
    s_axi_arvalid <= 1'b0;
    wt(s_axi_rvalid);
    chk({s_axi_rresp, s_axi_rdata}, e);
  endtask
  task wd;
    watchdog_underflow <= 1'b1;
    @(posedge aclk);
    watchdog_underflow <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  initial
  begin
    repeat (10) @(posedge aclk);
    chk({cpu_reset_n, sfr_full_reset, s_axi_bvalid, s_axi_rvalid}, 4'h4);
    aresetn <= 1'b1;
    foreach (rows[i])
    begin
      pin_req <= rows[i][17];
      boot_mode_strap <= rows[i][16];
      bus_width_8 <= rows[i][15];
      hold_request <= rows[i][14];
      repeat (30) @(posedge aclk);
      chk({osc_reset, cpu_reset_n, port0_oe, port1_oe, addr_oe, write_strobe_n_out, write_strobe_n_oe,
        read_strobe_n_out, read_strobe_n_oe, upper_lane_enable_n_oe, bus_clock_oe, hold_acknowledge,
        hold_acknowledge_oe, aux_high_out, aux_high_oe}, {rows[i][17], rows[i][13:0]});
      chk(pins_in_reset, !rows[i][13]);
    end
    rq(`RSC_CTRL_OFFSET, 34'h0);
    rq(12'h008, 34'h200000000);
    wr(`RSC_STATUS_OFFSET, 32'h1);
    chk(rsp, `RSC_RESP_SLVERR);
    bo_req <= 1'b1;
    repeat (5) @(posedge aclk);
    chk(cpu_reset_n, 1'b1);
    stop_mode <= 1'b1;
    wr(`RSC_CTRL_OFFSET, 32'h32);
    repeat (5) @(posedge aclk);
    chk(cpu_reset_n, 1'b1);
    stop_mode <= 1'b0;
    n = 0;
    wt(sfr_full_reset);
    chk(sfr_partial_reset, 1'b0);
    bo_req <= 1'b0;
    n = 0;
    wt(cpu_reset_n);
    chk(n >= BO + 2 && n <= BO + 6, 1'b1);
    rq(`RSC_CTRL_OFFSET, 34'h32);
    rq(`RSC_STATUS_OFFSET, 34'h09);
    wr(`RSC_CTRL_OFFSET, 32'h33);
    n = 0;
    wt(sfr_partial_reset);
    chk(sfr_full_reset, 1'b0);
    wt(fetch_reset_vector);
    rq(`RSC_CTRL_OFFSET, 34'h32);
    rq(`RSC_STATUS_OFFSET, 34'h11);
    wd();
    chk(cpu_reset_n, 1'b1);
    wr(`RSC_CTRL_OFFSET, 32'h36);
    wd();
    chk({sfr_partial_reset, sfr_full_reset}, 2'h2);
    n = 0;
    wt(fetch_reset_vector);
    rq(`RSC_CTRL_OFFSET, 34'h32);
    rq(`RSC_STATUS_OFFSET, 34'h19);
    ram_write_busy <= 1'b1;
    pin_req <= 1'b1;
    repeat (3) @(posedge aclk);
    pin_req <= 1'b0;
    ram_write_busy <= 1'b0;
    n = 0;
    wt(fetch_reset_vector);
    rq(`RSC_CTRL_OFFSET, 34'h0);
    rq(`RSC_STATUS_OFFSET, 34'h21);
    rq(`RSC_STATUS_OFFSET, 34'h01);
    // A bus reset in mid-run must come back through the pin-reset path.
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    chk({cpu_reset_n, sfr_full_reset, fetch_reset_vector, s_axi_rvalid}, 4'h4);
    aresetn <= 1'b1;
    n = 0;
    wt(fetch_reset_vector);
    chk(n, 34'd2);
    rq(`RSC_STATUS_OFFSET, 34'h01);
    summarize();
  end
endmodule
